// >>> verilog/wcs_wake_ctrl.sv
// wake, interrupt and watchdog-reset control with clock selection and axi4-lite registers
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`default_nettype none
`include "wcs_regs.svh"
module wcs_wake_ctrl (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire wcs_pkg::wcs_evt_t i_evt,
    input wire logic i_main_osc_sel_hi,
    input wire logic i_main_osc_sel_lo,
    input wire logic i_sub_osc_sel,
    output wcs_pkg::wcs_mode_t o_mode,
    output logic o_wake,
    output logic [7:0] o_core_irq,
    output logic o_wdt_reset,
    output wcs_pkg::wcs_clk_t o_clk,
    output logic o_irq
);
    import wcs_pkg::*;

    typedef struct packed {
        wcs_ax_t aw;
        wcs_w_t w;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        wcs_mode_t mode;
        logic ext_clk;
        logic [2:0] pll;
        logic [7:0] mask;
        logic [8:0] stat;
        logic [8:0] ien;
        logic wake;
        logic [7:0] core_irq;
        logic [3:0] wdt_cnt;
    } wcs_state_t;

    wcs_state_t st_r;
    wcs_state_t st_nxt;
    logic [7:0] src;
    logic [7:0] wake_en;
    logic [7:0] irq_en;
    logic [8:0] evt_set;
    logic [8:0] w1c;
    logic wdt_hit;
    logic dormant;
    logic [31:0] rd_word;
    logic rd_ok;

    assign src = {i_evt.port_chg, i_evt.lpw, i_evt.hpw, i_evt.cnt2, i_evt.cnt1,
        i_evt.pin_b, i_evt.pin_a, i_evt.tmr_ovf};
    assign dormant = (st_r.mode == WCS_SLEEP) || (st_r.mode == WCS_IDLE);
    assign wdt_hit = i_evt.wdt && (st_r.mode != WCS_SLEEP);

    // per-source wake and interrupt policy
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_src
            always_comb begin
                wake_en[g] = 1'b0;
                irq_en[g] = 1'b0;
                if (g == `WCS_BIT_PCHG) begin
                    wake_en[g] = src[g] && dormant;
                    irq_en[g] = src[g] && dormant && st_r.mask[g];
                end else if (g == `WCS_BIT_PINA || g == `WCS_BIT_PINB) begin
                    wake_en[g] = src[g] && st_r.mask[g] && dormant;
                    irq_en[g] = src[g] && st_r.mask[g];
                end else if (g == `WCS_BIT_TIMER) begin
                    wake_en[g] = src[g] && st_r.mask[g] && (st_r.mode == WCS_IDLE)
                        && st_r.ext_clk;
                    irq_en[g] = src[g] && st_r.mask[g] && (st_r.mode != WCS_SLEEP);
                end else begin
                    wake_en[g] = src[g] && st_r.mask[g] && (st_r.mode == WCS_IDLE);
                    irq_en[g] = src[g] && st_r.mask[g] && (st_r.mode != WCS_SLEEP);
                end
            end
        end
    endgenerate

    assign evt_set = {wdt_hit, irq_en | wake_en};

    always_comb begin
        rd_ok = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (i_araddr)
            `WCS_OFF_CTRL: rd_word = {25'h0, st_r.pll, 1'b0, st_r.ext_clk, st_r.mode};
            `WCS_OFF_MASK: rd_word = {24'h0, st_r.mask};
            `WCS_OFF_STAT: rd_word = {23'h0, st_r.stat};
            `WCS_OFF_IEN: rd_word = {23'h0, st_r.ien};
            `WCS_OFF_INFO: rd_word = {18'h0, o_clk.mul_num, o_clk.mul, o_clk.sub_xtal,
                o_clk.main_osc};
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        w1c = 9'h000;
        st_nxt.wake = 1'b0;
        st_nxt.core_irq = irq_en;
        if (!st_r.aw.valid && i_awvalid) begin
            st_nxt.aw = '{addr: i_awaddr, valid: 1'b1};
        end
        if (!st_r.w.valid && i_wvalid) begin
            st_nxt.w = '{data: i_wdata, strb: i_wstrb, valid: 1'b1};
        end
        if (st_r.aw.valid && st_r.w.valid && !st_r.bvalid) begin
            st_nxt.aw.valid = 1'b0;
            st_nxt.w.valid = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `WCS_RESP_OKAY;
            unique case (st_r.aw.addr)
                `WCS_OFF_CTRL: begin
                    if (st_r.w.strb[0]) begin
                        st_nxt.mode = wcs_mode_t'(st_r.w.data[1:0]);
                        st_nxt.ext_clk = st_r.w.data[`WCS_CTRL_EXTCLK_BIT];
                        st_nxt.pll = st_r.w.data[`WCS_CTRL_PLL_LSB +: 3];
                    end
                end
                `WCS_OFF_MASK: begin
                    if (st_r.w.strb[0]) begin
                        st_nxt.mask = st_r.w.data[7:0];
                    end
                end
                `WCS_OFF_STAT: begin
                    w1c = {st_r.w.strb[1] & st_r.w.data[8],
                        st_r.w.strb[0] ? st_r.w.data[7:0] : 8'h00};
                end
                `WCS_OFF_IEN: begin
                    if (st_r.w.strb[0]) begin
                        st_nxt.ien[7:0] = st_r.w.data[7:0];
                    end
                    if (st_r.w.strb[1]) begin
                        st_nxt.ien[8] = st_r.w.data[8];
                    end
                end
                `WCS_OFF_INFO: begin
                end
                default: st_nxt.bresp = `WCS_RESP_SLVERR;
            endcase
        end
        if (st_r.bvalid && i_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // set wins over a simultaneous write-one-to-clear
        st_nxt.stat = (st_r.stat & ~w1c) | evt_set;
        if (st_r.rvalid && i_rready) begin
            st_nxt.rvalid = 1'b0;
        end else if (!st_r.rvalid && i_arvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_word;
            st_nxt.rresp = rd_ok ? `WCS_RESP_OKAY : `WCS_RESP_SLVERR;
        end
        // a wake returns the core to normal running
        if (|wake_en) begin
            st_nxt.wake = 1'b1;
            st_nxt.mode = WCS_NORMAL;
        end
        // watchdog reset pulse is stretched so the core sees it reliably
        if (wdt_hit) begin
            st_nxt.wdt_cnt = 4'(`WCS_WDT_RST_CYC);
            st_nxt.mode = WCS_NORMAL;
        end else if (st_r.wdt_cnt != 4'h0) begin
            st_nxt.wdt_cnt = st_r.wdt_cnt - 4'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    wcs_clk_sel u_clk_sel (
        .i_main_osc_sel_hi(i_main_osc_sel_hi),
        .i_main_osc_sel_lo(i_main_osc_sel_lo),
        .i_sub_osc_sel(i_sub_osc_sel),
        .i_pll_mult_sel(st_r.pll),
        .o_clk(o_clk)
    );

    assign o_awready = !st_r.aw.valid;
    assign o_wready = !st_r.w.valid;
    assign o_bvalid = st_r.bvalid;
    assign o_bresp = st_r.bresp;
    assign o_arready = !st_r.rvalid;
    assign o_rvalid = st_r.rvalid;
    assign o_rdata = st_r.rdata;
    assign o_rresp = st_r.rresp;
    assign o_mode = st_r.mode;
    assign o_wake = st_r.wake;
    assign o_core_irq = st_r.core_irq;
    assign o_wdt_reset = st_r.wdt_cnt != 4'h0;
    assign o_irq = |(st_r.stat & st_r.ien);

    a_sleep_no_timer: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r.mode == WCS_SLEEP && i_evt.tmr_ovf && !i_evt.pin_a && !i_evt.pin_b
        && !i_evt.port_chg) |=> !o_wake) else $error("timer woke sleep");
    a_pin_wakes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (dormant && i_evt.pin_a && st_r.mask[1]) |=> (o_wake && o_core_irq[1]))
        else $error("pin a did not wake");
    a_pin_run_irq: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (!dormant && i_evt.pin_b && st_r.mask[2]) |=> o_core_irq[2])
        else $error("pin b no irq");
    a_port_chg_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (dormant && i_evt.port_chg) |=> (o_wake && (o_core_irq[7] == $past(st_r.mask[7]))))
        else $error("port change wake wrong");
    a_port_chg_run: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !dormant |=> !o_core_irq[7]) else $error("port change irq while running");
    a_idle_cnt_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r.mode == WCS_IDLE && i_evt.cnt1 && st_r.mask[3]) |=> o_wake)
        else $error("counter did not wake idle");
    a_wdt_sleep: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r.mode == WCS_SLEEP && i_evt.wdt && st_r.wdt_cnt == 4'h0) |=> !o_wdt_reset)
        else $error("watchdog acted in sleep");
    // ten cycles of reset pulse, split so each repetition count stays small
    a_wdt_reset: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_r.mode != WCS_SLEEP && i_evt.wdt) |=> (o_wdt_reset[*8] ##1 o_wdt_reset[*2]))
        else $error("watchdog reset too short");
    a_pll_source: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_clk.main_from_sub == (o_clk.main_osc == WCS_OSC_PLL))
        else $error("pll not from sub clock");
    a_pll_mul: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_r.pll[2] |-> (o_clk.mul_num == 8'hF4)) else $error("x244 wrong");
endmodule
`default_nettype wire

// >>> verilog/wcs_regs.svh
// register offsets, field positions, reset values and timing counts for wake/clock select
`ifndef WCS_REGS_SVH
`define WCS_REGS_SVH
`define WCS_OFF_CTRL 12'h000
`define WCS_OFF_MASK 12'h004
`define WCS_OFF_STAT 12'h008
`define WCS_OFF_IEN 12'h00C
`define WCS_OFF_INFO 12'h010
`define WCS_CTRL_MODE_LSB 0
`define WCS_CTRL_EXTCLK_BIT 2
`define WCS_CTRL_PLL_LSB 4
`define WCS_CTRL_RESET 32'h0000_0000
`define WCS_MASK_RESET 8'h00
`define WCS_BIT_TIMER 0
`define WCS_BIT_PINA 1
`define WCS_BIT_PINB 2
`define WCS_BIT_PCHG 7
`define WCS_STAT_WDT_BIT 8
`define WCS_RESP_OKAY 2'h0
`define WCS_RESP_SLVERR 2'h2
`define WCS_WDT_RST_NS 100
`define WCS_WDT_RST_CYC ((`WCS_WDT_RST_NS + 9) / 10)
`endif

// >>> verilog/wcs_pkg.sv
// types shared by the wake and clock select block
`default_nettype none
package wcs_pkg;
    typedef enum logic [1:0] {
        WCS_NORMAL = 2'h0,
        WCS_GREEN = 2'h1,
        WCS_IDLE = 2'h3,
        WCS_SLEEP = 2'h2
    } wcs_mode_t;

    typedef enum logic [1:0] {
        WCS_OSC_RC = 2'h0,
        WCS_OSC_XTAL = 2'h1,
        WCS_OSC_PLL = 2'h2
    } wcs_osc_t;

    typedef enum logic [2:0] {
        WCS_MUL_130 = 3'h0,
        WCS_MUL_65 = 3'h1,
        WCS_MUL_65_2 = 3'h2,
        WCS_MUL_65_4 = 3'h3,
        WCS_MUL_244 = 3'h4
    } wcs_mul_t;

    typedef struct packed {
        logic [11:0] addr;
        logic valid;
    } wcs_ax_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0] strb;
        logic valid;
    } wcs_w_t;

    typedef struct packed {
        logic tmr_ovf;
        logic pin_a;
        logic pin_b;
        logic cnt1;
        logic cnt2;
        logic hpw;
        logic lpw;
        logic port_chg;
        logic wdt;
    } wcs_evt_t;

    typedef struct packed {
        wcs_osc_t main_osc;
        logic sub_xtal;
        logic main_from_sub;
        wcs_mul_t mul;
        logic [7:0] mul_num;
        logic [2:0] mul_shift;
    } wcs_clk_t;
endpackage
`default_nettype wire

// >>> verilog/wcs_clk_sel.sv
// oscillator type decode and pll multiplier decode
`default_nettype none
`include "wcs_regs.svh"
module wcs_clk_sel (
    input wire logic i_main_osc_sel_hi,
    input wire logic i_main_osc_sel_lo,
    input wire logic i_sub_osc_sel,
    input wire logic [2:0] i_pll_mult_sel,
    output wcs_pkg::wcs_clk_t o_clk
);
    import wcs_pkg::*;
    always_comb begin
        o_clk = '0;
        if (i_main_osc_sel_hi) begin
            o_clk.main_osc = WCS_OSC_PLL;
        end else if (i_main_osc_sel_lo) begin
            o_clk.main_osc = WCS_OSC_XTAL;
        end else begin
            o_clk.main_osc = WCS_OSC_RC;
        end
        o_clk.sub_xtal = i_sub_osc_sel;
        o_clk.main_from_sub = i_main_osc_sel_hi;
        // multiplier expressed as num * fs >> shift
        if (i_pll_mult_sel[2]) begin
            o_clk.mul = WCS_MUL_244;
            o_clk.mul_num = 8'hF4;
            o_clk.mul_shift = 3'h0;
        end else begin
            unique case (i_pll_mult_sel[1:0])
                2'h0: begin
                    o_clk.mul = WCS_MUL_130;
                    o_clk.mul_num = 8'h82;
                    o_clk.mul_shift = 3'h0;
                end
                2'h1: begin
                    o_clk.mul = WCS_MUL_65;
                    o_clk.mul_num = 8'h41;
                    o_clk.mul_shift = 3'h0;
                end
                2'h2: begin
                    o_clk.mul = WCS_MUL_65_2;
                    o_clk.mul_num = 8'h41;
                    o_clk.mul_shift = 3'h1;
                end
                2'h3: begin
                    o_clk.mul = WCS_MUL_65_4;
                    o_clk.mul_num = 8'h41;
                    o_clk.mul_shift = 3'h2;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> test/wcs_src_model.sv
// event source and core-side observer facing the wake block
`default_nettype none
module wcs_src_model (
    input wire logic i_core_clk,
    input wire logic i_go,
    input wire logic i_clr,
    input wire logic [8:0] i_req,
    input wire logic i_wake,
    input wire logic [7:0] i_core_irq,
    input wire logic i_wdt_reset,
    output wcs_pkg::wcs_evt_t o_evt,
    output logic [8:0] o_acc,
    output logic [7:0] o_rst_cyc
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_evt = '0;
        o_acc = 9'h000;
        o_rst_cyc = 8'h00;
    end
    // sources strobe for a single cycle; the core side only accumulates what it saw,
    // so a pulse that lands a cycle late still shows up here
    always @(posedge i_core_clk) begin
        o_evt <= i_go ? wcs_pkg::wcs_evt_t'(i_req) : '0;
        o_acc <= i_clr ? 9'h000 : (o_acc | {i_wake, i_core_irq});
        o_rst_cyc <= i_clr ? 8'h00 : o_rst_cyc + {7'h00, i_wdt_reset};
    end
endmodule
`default_nettype wire

// >>> test/wake_and_clock_source_select_tb.sv
// self-checking bench for the wake and clock select block
`default_nettype none
`include "wcs_regs.svh"
module wake_and_clock_source_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import wcs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, wake, wdt_rst, irq;
    logic [1:0] bresp, rresp;
    logic hi = 0, lo = 0, sub = 0, go = 0, clr = 0;
    logic [8:0] req = 9'h000, acc;
    logic [7:0] cirq, rcyc;
    wcs_evt_t evt;
    wcs_mode_t mode;
    wcs_clk_t clko;
    logic [7:0] num_tab [0:4] = '{8'h82, 8'h41, 8'h41, 8'h41, 8'hF4};
    logic [2:0] sh_tab [0:4] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h0};
    logic [1:0] md, em;
    logic wk, ir;
    int err_count = 0, check_count = 0, k, m, s, j;

    always #5 clk = ~clk;

    wcs_wake_ctrl dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_evt(evt),
        .i_main_osc_sel_hi(hi), .i_main_osc_sel_lo(lo), .i_sub_osc_sel(sub),
        .o_mode(mode), .o_wake(wake), .o_core_irq(cirq), .o_wdt_reset(wdt_rst),
        .o_clk(clko), .o_irq(irq)
    );
    wcs_src_model u_src (
        .i_core_clk(clk), .i_go(go), .i_clr(clr), .i_req(req), .i_wake(wake),
        .i_core_irq(cirq), .i_wdt_reset(wdt_rst), .o_evt(evt), .o_acc(acc),
        .o_rst_cyc(rcyc)
    );

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_evt(input logic [10:0] g, input logic [10:0] e);
        chk_word({21'h0, g}, {21'h0, e});
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw;
        logic w;
        int n;
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            n++;
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                bready <= 1'b0;
                chk_word({30'h0, bresp}, {30'h0, er});
                break;
            end
            if (n > 50) begin
                err_count++;
                report_and_stop();
            end
        end
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] e, input logic [31:0] msk,
                            input logic [1:0] er);
        logic ar;
        int n;
        ar = 1'b1;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            n++;
            if (ar && arready) begin
                ar = 1'b0;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                rready <= 1'b0;
                chk_word(rdata & msk, e);
                chk_word({30'h0, rresp}, {30'h0, er});
                break;
            end
            if (n > 50) begin
                err_count++;
                report_and_stop();
            end
        end
    endtask

    // s is the core irq bit; 8 stands for the watchdog, the lsb of the event struct
    task automatic fire(input logic [31:0] c, input int sx, input logic [10:0] e,
                        input logic [10:0] msk);
        axi_write(`WCS_OFF_CTRL, c, `WCS_RESP_OKAY);
        @(posedge clk);
        req <= 9'h100 >> sx;
        go <= 1'b1;
        clr <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        clr <= 1'b0;
        // long enough for the whole watchdog reset pulse to be counted
        repeat (14) @(posedge clk);
        #1;
        chk_evt({mode, acc} & msk, e);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        axi_read(`WCS_OFF_CTRL, 32'h0, 32'hFFFFFFFF, `WCS_RESP_OKAY);
        axi_read(`WCS_OFF_MASK, 32'h0, 32'hFFFFFFFF, `WCS_RESP_OKAY);
        for (k = 0; k < 8; k++) begin
            {sub, hi, lo} <= 3'(k);
            em = k[1] ? 2'h2 : {1'b0, k[0]};
            axi_read(`WCS_OFF_INFO, {29'h0, k[2], em}, 32'h7, `WCS_RESP_OKAY);
            chk_word({28'h0, clko.main_osc, clko.sub_xtal, clko.main_from_sub},
                     {28'h0, em, k[2], k[1]});
        end
        for (k = 0; k < 8; k++) begin
            j = (k > 3) ? 4 : k;
            axi_write(`WCS_OFF_CTRL, k << 4, `WCS_RESP_OKAY);
            chk_word({18'h0, clko.mul, clko.mul_num, clko.mul_shift},
                     {18'h0, 3'(j), num_tab[j], sh_tab[j]});
            axi_read(`WCS_OFF_INFO, {18'h0, num_tab[j], 3'(j), 3'h6}, 32'h3FFF,
                     `WCS_RESP_OKAY);
        end
        axi_write(12'h020, 32'h0, `WCS_RESP_SLVERR);
        axi_read(12'h020, 32'h0, 32'h0, `WCS_RESP_SLVERR);
        axi_write(`WCS_OFF_MASK, 32'hFF, `WCS_RESP_OKAY);
        for (m = 0; m < 4; m++) begin
            for (s = 0; s < 8; s++) begin
                md = 2'(m);
                wk = (md == WCS_SLEEP && (s == 1 || s == 2 || s == 7)) || md == WCS_IDLE;
                ir = (md == WCS_SLEEP) ? (s == 1 || s == 2 || s == 7)
                    : (md == WCS_IDLE || s != 7);
                em = wk ? 2'h0 : md;
                fire({29'h0, 1'b1, md}, s, {em, wk, ir ? 8'h01 << s : 8'h00},
                     11'h7FF);
            end
        end
        // timer clocked internally must leave idle alone
        fire(32'h3, 0, {2'h3, 1'b0, 8'h00}, 11'h700);
        axi_write(`WCS_OFF_MASK, 32'h7D, `WCS_RESP_OKAY);
        fire(32'h2, 7, {2'h0, 1'b1, 8'h00}, 11'h7FF);
        fire(32'h2, 1, {2'h2, 1'b0, 8'h00}, 11'h7FF);
        for (m = 0; m < 4; m++) begin
            md = 2'(m);
            em = (md == WCS_SLEEP) ? md : 2'h0;
            fire({30'h0, md}, 8, {em, 9'h000}, 11'h700);
            chk_word({24'h0, rcyc}, (md == WCS_SLEEP) ? 32'h0 : `WCS_WDT_RST_CYC);
        end
        axi_write(`WCS_OFF_STAT, 32'h1FF, `WCS_RESP_OKAY);
        axi_read(`WCS_OFF_STAT, 32'h0, 32'h1FF, `WCS_RESP_OKAY);
        axi_write(`WCS_OFF_MASK, 32'hFF, `WCS_RESP_OKAY);
        fire(32'h0, 1, {2'h0, 1'b0, 8'h02}, 11'h7FF);
        axi_read(`WCS_OFF_STAT, 32'h002, 32'h1FF, `WCS_RESP_OKAY);
        axi_write(`WCS_OFF_IEN, 32'h002, `WCS_RESP_OKAY);
        chk_word({31'h0, irq}, 32'h1);
        axi_write(`WCS_OFF_IEN, 32'h000, `WCS_RESP_OKAY);
        chk_word({31'h0, irq}, 32'h0);
        axi_write(`WCS_OFF_IEN, 32'h002, `WCS_RESP_OKAY);
        axi_write(`WCS_OFF_STAT, 32'h002, `WCS_RESP_OKAY);
        axi_read(`WCS_OFF_STAT, 32'h0, 32'h1FF, `WCS_RESP_OKAY);
        chk_word({31'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
